// File: cirq_pkg.sv
// shared constants, types and helpers for the cascaded interrupt controller
package cirq_pkg;

    // port addresses of the two controllers
    localparam logic [7:0] MASTER_EVEN = 8'h20;
    localparam logic [7:0] MASTER_ODD  = 8'h21;
    localparam logic [7:0] SLAVE_EVEN  = 8'hA0;
    localparam logic [7:0] SLAVE_ODD   = 8'hA1;

    // controller indices and request line count
    localparam int unsigned MASTER    = 0;
    localparam int unsigned SLAVE     = 1;
    localparam int unsigned IRQ_LINES = 16;

    // field positions in the written words
    localparam int unsigned WORD_ONE_BIT  = 4;
    localparam int unsigned SINGLE_BIT    = 1;
    localparam int unsigned NEED_FOUR_BIT = 0;
    localparam int unsigned VEC_LSB       = 3;
    localparam int unsigned SPECIAL_FULLY_NESTED_BIT      = 4;
    localparam int unsigned AUTOMATIC_END_OF_SERVICE_BIT      = 1;
    localparam int unsigned OP_THREE_BIT  = 3;
    localparam int unsigned EOI_BIT       = 5;
    localparam int unsigned SPECIFIC_BIT  = 6;
    localparam int unsigned ESMM_BIT      = 6;
    localparam int unsigned SMM_BIT       = 5;
    localparam int unsigned RR_BIT        = 1;
    localparam int unsigned RIS_BIT       = 0;

    // values loaded by the first initialization word, and the spurious level
    localparam logic [7:0] CASC_AFTER_INIT = 8'h02;
    localparam logic [7:0] MASK_AFTER_INIT = 8'h00;
    localparam logic [2:0] SPURIOUS_LEVEL  = 3'h7;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_W2   = 5'h02,
        ST_W3   = 5'h04,
        ST_W4   = 5'h08,
        ST_RUN  = 5'h10
    } cirq_step_t;

    typedef enum logic [1:0] {
        AK_WAIT   = 2'h1,
        AK_SECOND = 2'h2
    } cirq_ack_t;

    typedef struct packed {
        cirq_step_t step;
        logic [7:0] master_request_pending;
        logic [7:0] master_in_service;
        logic [7:0] mask;
        logic [7:0] casc;
        logic [4:0] vecHi;
        logic       needFour;
        logic       single;
        logic       special_fully_nested;
        logic       automatic_end_of_service;
        logic       readIsr;
        logic       specialMask;
    } cirq_ctrl_t;

    // one host port access, single-cycle strobes
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } cirq_io_t;

    typedef struct packed {
        logic [7:0] data;
        logic       oe;
    } cirq_drive_t;

    typedef struct packed {
        cirq_ctrl_t [1:0] ctl;
        cirq_ack_t        ack;
        logic [2:0]       akMLevel;
        logic [2:0]       akLevel;
        logic             akSlave;
        logic             akDrive;
        logic             akSpur;
        logic             akMSet;
        logic             intr;
        cirq_drive_t      drive;
    } cirq_top_t;

    typedef struct packed {
        logic [IRQ_LINES-1:0] s1;
        logic [IRQ_LINES-1:0] s2;
        logic [IRQ_LINES-1:0] s3;
        logic [IRQ_LINES-1:0] stable;
    } cirq_sync_t;

    localparam cirq_ctrl_t CTRL_RESET = '{step: ST_IDLE, master_request_pending: 8'h00,
        master_in_service: 8'h00, mask: 8'h00, casc: 8'h00, vecHi: 5'h00,
        needFour: 1'h0, single: 1'h0, special_fully_nested: 1'h0, automatic_end_of_service: 1'h0,
        readIsr: 1'h0, specialMask: 1'h0};

    localparam cirq_top_t TOP_RESET = '{ctl: '{CTRL_RESET, CTRL_RESET},
        ack: AK_WAIT, akMLevel: 3'h0, akLevel: 3'h0, akSlave: 1'h0,
        akDrive: 1'h0, akSpur: 1'h0, akMSet: 1'h0, intr: 1'h0,
        drive: '{data: 8'h00, oe: 1'h0}};

    // inactive request pins idle high
    localparam cirq_sync_t SYNC_RESET = '{s1: 16'hFFFF, s2: 16'hFFFF,
        s3: 16'hFFFF, stable: 16'hFFFF};

    // {found, level}; level 0 ranks highest
    function automatic logic [3:0] highest(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : highest

    // one port write into one controller's state
    function automatic cirq_ctrl_t portWrite(input cirq_ctrl_t cur,
                                             input logic       odd,
                                             input logic [7:0] val);
        cirq_ctrl_t nxt;
        logic [3:0] top;
        nxt = cur;
        top = highest(cur.master_in_service);
        if (!odd) begin
            if (val[WORD_ONE_BIT]) begin
                // fixed priority is the only order kept here
                nxt.step        = ST_W2;
                nxt.mask        = MASK_AFTER_INIT;
                nxt.master_in_service         = 8'h00;
                nxt.specialMask = 1'h0;
                nxt.readIsr     = 1'h0;
                nxt.casc        = CASC_AFTER_INIT;
                nxt.special_fully_nested        = 1'h0;
                nxt.automatic_end_of_service        = 1'h0;
                nxt.needFour    = val[NEED_FOUR_BIT];
                nxt.single      = val[SINGLE_BIT];
            end else if (cur.step == ST_RUN) begin
                if (val[OP_THREE_BIT]) begin
                    if (val[ESMM_BIT]) begin
                        nxt.specialMask = val[SMM_BIT];
                    end
                    if (val[RR_BIT]) begin
                        nxt.readIsr = val[RIS_BIT];
                    end
                end else if (val[EOI_BIT]) begin
                    if (val[SPECIFIC_BIT]) begin
                        nxt.master_in_service[val[2:0]] = 1'h0;
                    end else if (top[3]) begin
                        nxt.master_in_service[top[2:0]] = 1'h0;
                    end
                end
            end
        end else begin
            case (cur.step)
                ST_W2: begin
                    nxt.vecHi = val[7:VEC_LSB];
                    if (!cur.single) begin
                        nxt.step = ST_W3;
                    end else if (cur.needFour) begin
                        nxt.step = ST_W4;
                    end else begin
                        nxt.step = ST_RUN;
                    end
                end
                ST_W3: begin
                    nxt.casc = val;
                    if (cur.needFour) begin
                        nxt.step = ST_W4;
                    end else begin
                        nxt.step = ST_RUN;
                    end
                end
                ST_W4: begin
                    nxt.special_fully_nested = val[SPECIAL_FULLY_NESTED_BIT];
                    nxt.automatic_end_of_service = val[AUTOMATIC_END_OF_SERVICE_BIT];
                    nxt.step = ST_RUN;
                end
                ST_RUN: begin
                    nxt.mask = val;
                end
                default: begin
                    nxt = cur;
                end
            endcase
        end
        return nxt;
    endfunction : portWrite

endpackage : cirq_pkg

// File: cirq_sync.sv
// three-stage synchroniser with agreement filter for the request pins
`timescale 1ns/1ps
`default_nettype none
module cirq_sync (
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rstSync_n,
    // pins and filtered levels
    input  wire logic [cirq_pkg::IRQ_LINES-1:0] rawIn,
    output logic      [cirq_pkg::IRQ_LINES-1:0] filtered
);
    cirq_pkg::cirq_sync_t q;
    cirq_pkg::cirq_sync_t d;
    logic [cirq_pkg::IRQ_LINES-1:0] agree;

    always_comb begin
        d      = q;
        d.s1   = rawIn;
        d.s2   = q.s1;
        d.s3   = q.s2;
        // a level counts only once stages two and three agree
        agree    = ~(q.s2 ^ q.s3);
        d.stable = (q.s3 & agree) | (q.stable & ~agree);
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            q <= cirq_pkg::SYNC_RESET;
        end else begin
            q <= d;
        end
    end

    assign filtered = q.stable;

    // a filtered bit moves only to a level both late stages agreed on
    property p_sync_agree;
        @(posedge ref_clk) disable iff (!rstSync_n)
        (((q.stable ^ $past(q.stable))
            & (($past(q.s2) ^ $past(q.s3)) | (q.stable ^ $past(q.s3))))
            == '0);
    endproperty
    a_sync_agree: assert property (p_sync_agree)
        else $error("filtered level changed without agreement");

endmodule : cirq_sync
`default_nettype wire

// File: cirq_decide.sv
// priority decision for one eight-input controller, fixed priority
`timescale 1ns/1ps
`default_nettype none
module cirq_decide (
    // controller state
    input  wire logic [7:0] master_request_pending,
    input  wire logic [7:0] mask,
    input  wire logic [7:0] master_in_service,
    input  wire logic       specialMask,
    input  wire logic [7:0] nestOpen,
    // decision
    output logic            want,
    output logic [2:0]      level
);
    logic [3:0] reqTop;
    logic [3:0] blkTop;

    always_comb begin
        reqTop = cirq_pkg::highest(master_request_pending & ~mask);
        // with special masking a masked in-service level stops blocking
        blkTop = cirq_pkg::highest(specialMask ? (master_in_service & ~mask) : master_in_service);
        level  = reqTop[2:0];
        want   = reqTop[3] && (!blkTop[3] || reqTop[2:0] < blkTop[2:0]
                 || (reqTop[2:0] == blkTop[2:0] && nestOpen[reqTop[2:0]]));
    end

endmodule : cirq_decide
`default_nettype wire

// File: cirq_top.sv
// cascaded pair of eight-input interrupt controllers on host port pairs
// How it works
// - a low level on a request pin is an active request, no edge
// - request gone at first acknowledge: second acknowledge gives level 7
// - genuine level 7 sets in-service bit, spurious one leaves it clear
// - master decodes ports 20h/21h, slave decodes A0h/A1h
// - word one written to the even port starts a new initialization
// - word one clears mask, special masking, selects pending read, id 2
// - next odd-port writes load words two, three and four in order
// - requests are accepted only once initialization completes
// - master and slave hold separate, independent mode state
// - vector is word-two bits 3-7 above the serviced level
// - master word three marks inputs that carry a slave
// - slave word three bits 0-2 hold its id, matched to broadcast
// - second acknowledge drives an eight-bit vector to the processor
// - word four sets special fully nested and automatic end of service, both acted on by the master only
`timescale 1ns/1ps
`default_nettype none
module cirq_top (
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           reset_n,
    // host port access and acknowledge strobe
    input  wire cirq_pkg::cirq_io_t             hostIo,
    input  wire logic                           ackCycle,
    // request pins, active low
    input  wire logic [cirq_pkg::IRQ_LINES-1:0] irqLevel_n,
    // to the processor
    output logic                                intrReq,
    output cirq_pkg::cirq_drive_t               dataDrive
);
    logic [1:0]                     rstPipe_q;
    logic                           rstSync_n;
    logic [cirq_pkg::IRQ_LINES-1:0] syncd;
    cirq_pkg::cirq_top_t            q;
    cirq_pkg::cirq_top_t            d;
    logic                           mWant;
    logic [2:0]                     mLvl;
    logic                           sWant;
    logic [2:0]                     sLvl;
    logic [7:0]                     cascMap;
    logic [7:0]                     nestM;
    logic                           slaveSel;
    logic [4:0]                     respVecHi;
    logic                           mapped;

    // reset leaves through two flops so release is clean
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'h1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    cirq_sync u_sync (
        .ref_clk   (ref_clk),
        .rstSync_n (rstSync_n),
        .rawIn     (irqLevel_n),
        .filtered  (syncd)
    );

    // cascade map only counts when the master runs cascaded
    assign cascMap = q.ctl[cirq_pkg::MASTER].single ? 8'h00
                   : q.ctl[cirq_pkg::MASTER].casc;
    assign nestM   = q.ctl[cirq_pkg::MASTER].special_fully_nested ? cascMap : 8'h00;

    cirq_decide u_master (
        .master_request_pending         (q.ctl[cirq_pkg::MASTER].master_request_pending),
        .mask        (q.ctl[cirq_pkg::MASTER].mask),
        .master_in_service         (q.ctl[cirq_pkg::MASTER].master_in_service),
        .specialMask (q.ctl[cirq_pkg::MASTER].specialMask),
        .nestOpen    (nestM),
        .want        (mWant),
        .level       (mLvl)
    );

    cirq_decide u_slave (
        .master_request_pending         (q.ctl[cirq_pkg::SLAVE].master_request_pending),
        .mask        (q.ctl[cirq_pkg::SLAVE].mask),
        .master_in_service         (q.ctl[cirq_pkg::SLAVE].master_in_service),
        .specialMask (q.ctl[cirq_pkg::SLAVE].specialMask),
        .nestOpen    (8'h00),
        .want        (sWant),
        .level       (sLvl)
    );

    // slave answers only when its id matches the broadcast level
    assign slaveSel = cascMap[mLvl]
        && (q.ctl[cirq_pkg::SLAVE].casc[2:0] == mLvl);
    assign respVecHi = q.akSlave ? q.ctl[cirq_pkg::SLAVE].vecHi
                                 : q.ctl[cirq_pkg::MASTER].vecHi;
    assign mapped = hostIo.addr == cirq_pkg::MASTER_EVEN
        || hostIo.addr == cirq_pkg::MASTER_ODD
        || hostIo.addr == cirq_pkg::SLAVE_EVEN
        || hostIo.addr == cirq_pkg::SLAVE_ODD;

    always_comb begin
        d          = q;
        d.drive.oe = 1'h0;
        d.intr     = mWant;
        // once running, pending bits follow the pin level every cycle; master cascade inputs follow the slave's request
        d.ctl[cirq_pkg::SLAVE].master_request_pending =
            (q.ctl[cirq_pkg::SLAVE].step == cirq_pkg::ST_RUN)
            ? ~syncd[15:8] : 8'h00;
        d.ctl[cirq_pkg::MASTER].master_request_pending =
            (q.ctl[cirq_pkg::MASTER].step == cirq_pkg::ST_RUN)
            ? ((~syncd[7:0] & ~cascMap) | (cascMap & {8{sWant}}))
            : 8'h00;
        // each controller sees only its own pair of ports
        if (hostIo.wr) begin
            if (hostIo.addr == cirq_pkg::MASTER_EVEN
                || hostIo.addr == cirq_pkg::MASTER_ODD) begin
                d.ctl[cirq_pkg::MASTER] = cirq_pkg::portWrite(
                    d.ctl[cirq_pkg::MASTER], hostIo.addr[0],
                    hostIo.data);
            end
            if (hostIo.addr == cirq_pkg::SLAVE_EVEN
                || hostIo.addr == cirq_pkg::SLAVE_ODD) begin
                d.ctl[cirq_pkg::SLAVE] = cirq_pkg::portWrite(
                    d.ctl[cirq_pkg::SLAVE], hostIo.addr[0],
                    hostIo.data);
            end
        end
        if (hostIo.rd && mapped) begin
            d.drive.oe = 1'h1;
            if (hostIo.addr[0]) begin
                d.drive.data = q.ctl[hostIo.addr[7]].mask;
            end else if (q.ctl[hostIo.addr[7]].readIsr) begin
                d.drive.data = q.ctl[hostIo.addr[7]].master_in_service;
            end else begin
                d.drive.data = q.ctl[hostIo.addr[7]].master_request_pending;
            end
        end
        case (q.ack)
            cirq_pkg::AK_WAIT: begin
                if (ackCycle) begin
                    // request must still stand at this edge to be genuine
                    d.ack      = cirq_pkg::AK_SECOND;
                    d.akMSet   = mWant;
                    d.akMLevel = mWant ? mLvl : cirq_pkg::SPURIOUS_LEVEL;
                    d.akSlave  = mWant && slaveSel;
                    d.akDrive  = !(mWant && cascMap[mLvl] && !slaveSel);
                    d.akSpur   = !mWant || (slaveSel && !sWant);
                    d.akLevel  = cirq_pkg::SPURIOUS_LEVEL;
                    if (mWant) begin
                        d.ctl[cirq_pkg::MASTER].master_in_service[mLvl] = 1'h1;
                        d.akLevel = mLvl;
                        if (slaveSel) begin
                            d.akLevel = sWant ? sLvl
                                              : cirq_pkg::SPURIOUS_LEVEL;
                            if (sWant) begin
                                d.ctl[cirq_pkg::SLAVE].master_in_service[sLvl] = 1'h1;
                            end
                        end
                    end
                end
            end
            cirq_pkg::AK_SECOND: begin
                if (ackCycle) begin
                    d.ack = cirq_pkg::AK_WAIT;
                    if (q.akDrive) begin
                        d.drive.oe   = 1'h1;
                        d.drive.data = {respVecHi, q.akLevel};
                    end
                    // automatic end of service is kept to the master
                    if (q.akMSet && q.ctl[cirq_pkg::MASTER].automatic_end_of_service) begin
                        d.ctl[cirq_pkg::MASTER].master_in_service[q.akMLevel] = 1'h0;
                    end
                end
            end
            default: begin
                d.ack = cirq_pkg::AK_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            q <= cirq_pkg::TOP_RESET;
        end else begin
            q <= d;
        end
    end

    assign intrReq   = q.intr;
    assign dataDrive = q.drive;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSync_n);

    property p_level_follow;
        (q.ctl[1].step == cirq_pkg::ST_RUN)
            |=> q.ctl[1].master_request_pending == ~$past(syncd[15:8]);
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("slave pending bits do not follow pin levels");

    property p_spurious_vec;
        (q.ack == cirq_pkg::AK_SECOND && ackCycle && q.akDrive && q.akSpur)
            |=> dataDrive.oe && dataDrive.data[2:0] == 3'h7;
    endproperty
    a_spurious_vec: assert property (p_spurious_vec)
        else $error("spurious request did not give level 7");

    property p_spurious_isr;
        (q.ack == cirq_pkg::AK_WAIT && ackCycle && !mWant
            && !q.ctl[0].master_in_service[7]) |=> !q.ctl[0].master_in_service[7];
    endproperty
    a_spurious_isr: assert property (p_spurious_isr)
        else $error("spurious request set in-service bit");

    property p_genuine_isr;
        (q.ack == cirq_pkg::AK_WAIT && ackCycle && mWant && mLvl == 3'h7)
            |=> q.ctl[0].master_in_service[7] ##1 q.ack == cirq_pkg::AK_SECOND;
    endproperty
    a_genuine_isr: assert property (p_genuine_isr)
        else $error("genuine level 7 left in-service bit clear");

    property p_init_clear;
        (hostIo.wr && hostIo.addr == cirq_pkg::MASTER_EVEN
            && hostIo.data[cirq_pkg::WORD_ONE_BIT])
            |=> q.ctl[0].mask == cirq_pkg::MASK_AFTER_INIT
            && q.ctl[0].casc == cirq_pkg::CASC_AFTER_INIT
            && !q.ctl[0].specialMask && !q.ctl[0].readIsr
            && q.ctl[0].step == cirq_pkg::ST_W2;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("word one did not reset controller state");

    property p_word_two;
        (hostIo.wr && hostIo.addr == cirq_pkg::MASTER_ODD
            && q.ctl[0].step == cirq_pkg::ST_W2)
            |=> q.ctl[0].vecHi == $past(hostIo.data[7:3])
            && q.ctl[0].step != cirq_pkg::ST_W2;
    endproperty
    a_word_two: assert property (p_word_two)
        else $error("odd write after word one not taken as word two");

    property p_word_four;
        (hostIo.wr && hostIo.addr == cirq_pkg::SLAVE_ODD
            && q.ctl[1].step == cirq_pkg::ST_W4)
            |=> q.ctl[1].special_fully_nested == $past(hostIo.data[4])
            && q.ctl[1].automatic_end_of_service == $past(hostIo.data[1])
            && q.ctl[1].step == cirq_pkg::ST_RUN;
    endproperty
    a_word_four: assert property (p_word_four)
        else $error("word four mode bits not loaded");

    property p_not_ready;
        (q.ctl[0].step != cirq_pkg::ST_RUN) |=> q.ctl[0].master_request_pending == 8'h00;
    endproperty
    a_not_ready: assert property (p_not_ready)
        else $error("request pending before initialization done");

    property p_independent;
        (hostIo.wr && hostIo.addr[7]) |=> $stable(q.ctl[0].mask);
    endproperty
    a_independent: assert property (p_independent)
        else $error("slave write altered master mask");

    property p_vector;
        (q.ack == cirq_pkg::AK_SECOND && ackCycle && q.akDrive)
            |=> dataDrive.oe
            && dataDrive.data == {$past(respVecHi), $past(q.akLevel)};
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector not driven on second acknowledge");

    property p_slave_pick;
        (q.ack == cirq_pkg::AK_WAIT && ackCycle && mWant)
            |=> q.akSlave == $past(slaveSel);
    endproperty
    a_slave_pick: assert property (p_slave_pick)
        else $error("cascade responder chosen wrongly");

    property p_mask_read;
        (hostIo.rd && hostIo.addr == cirq_pkg::MASTER_ODD
            && !(ackCycle && q.ack == cirq_pkg::AK_SECOND))
            |=> dataDrive.oe && dataDrive.data == $past(q.ctl[0].mask);
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("odd port read did not return mask");

    property p_unmapped;
        (hostIo.rd && !mapped && !(ackCycle && q.ack == cirq_pkg::AK_SECOND))
            |=> !dataDrive.oe;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read drove the data bus");

    c_init_done: cover property (q.ctl[0].step == cirq_pkg::ST_RUN);
    c_spurious: cover property (q.ack == cirq_pkg::AK_SECOND && q.akSpur
        && ackCycle);
    c_slave_vec: cover property (q.ack == cirq_pkg::AK_SECOND && q.akSlave
        && ackCycle);

endmodule : cirq_top
`default_nettype wire

// File: cirq_host.sv
// host processor model: port accesses and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none
module cirq_host (
    // clock
    input  wire logic                  ref_clk,
    // requests to the controller pair
    output cirq_pkg::cirq_io_t         io,
    output logic                       ack,
    // answers
    input  wire cirq_pkg::cirq_drive_t drv
);
    initial begin
        io  = '0;
        ack = 1'b0;
    end
    // k: 0 write, 1 read, 2 acknowledge; answer taken one cycle on
    task automatic acc(input logic [1:0] k, input logic [7:0] a, d,
                       output logic [8:0] r);
        @(posedge ref_clk) #1;
        io  = '{addr: a, wr: k == 2'h0, rd: k == 2'h1, data: d};
        ack = (k == 2'h2);
        @(posedge ref_clk) #1;
        // released bus shows inverted values, not stale ones
        io  = '{addr: ~a, wr: 1'b0, rd: 1'b0, data: ~d};
        ack = 1'b0;
        r   = {drv.oe, drv.data};
    endtask : acc
endmodule : cirq_host
`default_nettype wire

// File: tb.sv
// self-checking bench for the cascaded controller pair
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  ref_clk    = 1'b0;
    logic                  reset_n    = 1'b0;
    logic [15:0]           irqLevel_n = 16'hFFBF;
    logic                  intrReq;
    logic                  ackCycle;
    cirq_pkg::cirq_io_t    hostIo;
    cirq_pkg::cirq_drive_t dataDrive;
    logic [8:0]            r;
    logic [31:0]           seed       = 32'h6DF5;
    logic [7:0]            mk;
    int                    mismatches = 0;
    int                    checked    = 0;
    int                    vecQ[$];
    // fixed word one 19h, then vector base, map or id, mode word
    logic [15:0] ini [8] = '{16'h2019, 16'h2108, 16'h2104, 16'h2101,
                             16'hA019, 16'hA170, 16'hA102,
                             16'hA101};
    always #5 ref_clk = ~ref_clk;
    cirq_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .hostIo(hostIo),
        .ackCycle(ackCycle), .irqLevel_n(irqLevel_n),
        .intrReq(intrReq), .dataDrive(dataDrive));
    cirq_host host (.ref_clk(ref_clk), .io(hostIo), .ack(ackCycle),
        .drv(dataDrive));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic cmp(input logic [8:0] g, e);
        checked++;
        if (!e[8]) g = {g[8], 8'h00}; // no answer: only oe counts
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %0h exp %0h", $time, g, e);
        end
    endtask : cmp
    task automatic cmpI(input logic e);
        checked++;
        if (intrReq !== e) begin
            mismatches++;
            $display("ERROR %0t got %0h exp %0h", $time, intrReq, e);
        end
    endtask : cmpI
    task automatic op(input logic [1:0] k, input logic [7:0] a, d,
                      input logic [8:0] e);
        host.acc(k, a, d, r);
        if (k != 2'h0) cmp(r, e);
    endtask : op
    task automatic rq(input int p, input logic hold, input logic [7:0] master_in_service);
        vecQ.push_back(!hold ? 8'h0F : p < 8 ? 8'h08 + p : 8'h68 + p);
        @(posedge ref_clk) #1 irqLevel_n[p] = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 cmpI(1'b1);
        irqLevel_n[p] = !hold;
        repeat (8) @(posedge ref_clk);
        op(2'h2, 8'h00, 8'h00, 9'h000);
        irqLevel_n[p] = 1'b1;
        op(2'h2, 8'h00, 8'h00, {1'b1, 8'(vecQ.pop_front())});
        op(2'h0, 8'h20, 8'h0B, 9'h000);
        op(2'h1, 8'h20, 8'h00, {1'b1, master_in_service});
        op(2'h0, 8'h20, 8'h20, 9'h000);
    endtask : rq
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    initial begin
        #100000;
        mismatches++;
        results();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 cmpI(1'b0);
        irqLevel_n = 16'hFFFF;
        op(2'h1, 8'h30, 8'h00, 9'h000);
        foreach (ini[i]) op(2'h0, ini[i][15:8], ini[i][7:0], 9'h0);
        op(2'h1, 8'h21, 8'h00, 9'h100);
        op(2'h1, 8'hA0, 8'h00, 9'h100);
        seed = xs(seed);
        // random mask keeps clear of the levels the scenarios raise
        mk = seed[7:0] & 8'h50;
        op(2'h0, 8'h21, mk, 9'h000);
        op(2'h1, 8'h21, 8'h00, {1'b1, mk});
        op(2'h1, 8'hA1, 8'h00, 9'h100);
        rq(3, 1'b1, 8'h08);
        rq(7, 1'b1, 8'h80);
        rq(5, 1'b0, 8'h00);
        rq(10, 1'b1, 8'h04);
        results();
    end
endmodule : tb
`default_nettype wire
